// [hw/vcs_serial_port.sv]
`timescale 1ns/1ps
// Operation
// (RL1) Words move most significant bit first, least significant last.
// (RL2) Word is 8 bits companded, 16 bits linear.
// (RL3) Fixed rate: receive bits sampled on master clock falling edges.
// (RL4) Fixed rate: bit 1 driven on rising edge, rest on following rises.
// (RL5) Fixed rate: data output released after falling edge of last bit.
// (RL6) Slot strobe low from bit 1 rise to last bit fall, fixed rate.
// (RL7) Host holds transmit sync high across a master clock fall.
// (RL8) Host holds receive sync high across a master clock fall.
// (RL9) Variable rate: bit 1 driven as transmit sync rises.
// (RL10) Variable rate: bits 2 onward on transmit data clock rises.
// (RL11) Variable rate: data output released when transmit sync falls.
// (RL12) Variable rate: receive bits sampled on receive data clock falls.
// (RL13) Host sets syncs up ahead of the matching data clock falls.
// (RL14) Receive data clock tied high selects fixed rate, clocked selects variable.
// (RL15) Variable rate: same word repeats while sync high and clock pulses.
// (RL16) Host keeps data clocks synchronous and aligned with master clock.
// (RL17) Transmit and receive paths run independently, each on its own sync.
module vcs_serial_port
  import vcs_pkg::*;
(
  input wire logic clk_i, // 200 MHz system clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic linear_mode_i, // 1 linear 16 bit, 0 companded 8 bit
  input wire logic master_clock_i, // Codec master clock pin
  input wire logic tx_frame_sync_i, // Transmit frame sync pin
  input wire logic rx_frame_sync_i, // Receive frame sync pin
  input wire logic tx_bit_clock_i, // Transmit data clock pin
  input wire logic rx_bit_clock_i, // Receive data clock pin, high = fixed rate
  input wire logic rx_data_i, // Serial receive data pin
  input wire logic [VCS_WORD_MAX-1:0] tx_word_i, // Word to send, left aligned
  output logic tx_word_ack_o, // Pulse: tx_word_i loaded
  output logic tx_data_o, // Serial transmit data
  output logic tx_data_oe_n_o, // Low while driving tx_data_o
  output logic tx_slot_strobe_n_o, // Slot strobe level, active low
  output logic tx_slot_strobe_oe_n_o, // Low while driving strobe
  output logic [VCS_WORD_MAX-1:0] rx_word_o, // Last received word, right aligned
  output logic rx_word_valid_o, // Pulse: rx_word_o updated
  output logic variable_rate_o // Current timing mode
);
  vcs_edge_if mclk();
  vcs_edge_if tx_frame_sync();
  vcs_edge_if rx_frame_sync();
  vcs_edge_if dcx();
  vcs_edge_if dcr();
  vcs_edge_if din();

  vcs_pin_sync u_mclk (.clk_i(clk_i), .rst_i(rst_i), .pin_i(master_clock_i), .edge_o(mclk));
  vcs_pin_sync u_fsx (.clk_i(clk_i), .rst_i(rst_i), .pin_i(tx_frame_sync_i), .edge_o(tx_frame_sync));
  vcs_pin_sync u_fsr (.clk_i(clk_i), .rst_i(rst_i), .pin_i(rx_frame_sync_i), .edge_o(rx_frame_sync));
  vcs_pin_sync u_dcx (.clk_i(clk_i), .rst_i(rst_i), .pin_i(tx_bit_clock_i), .edge_o(dcx));
  vcs_pin_sync u_dcr (.clk_i(clk_i), .rst_i(rst_i), .pin_i(rx_bit_clock_i), .edge_o(dcr));
  vcs_pin_sync u_din (.clk_i(clk_i), .rst_i(rst_i), .pin_i(rx_data_i), .edge_o(din));

  logic [VCS_CNT_W-1:0] word_len;
  logic [VCS_STRAP_W-1:0] strap_cnt_reg;
  logic var_reg;

  // (RL2) word length
  assign word_len = linear_mode_i ? VCS_CNT_LIN : VCS_CNT_COMP;

  // (RL14) strap detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_cnt_reg <= '0;
      var_reg <= 1'b0;
    end else if (dcr.fall) begin
      strap_cnt_reg <= '0;
      var_reg <= 1'b1;
    end else if (!dcr.level) begin
      strap_cnt_reg <= '0;
    end else if (strap_cnt_reg == VCS_STRAP_W'(VCS_STRAP_CYC)) begin
      var_reg <= 1'b0;
    end else begin
      strap_cnt_reg <= strap_cnt_reg + 1'b1;
    end
  end
  assign variable_rate_o = var_reg;

  // Transmit path
  vcs_tx_state_t tx_state_reg;
  logic [VCS_WORD_MAX-1:0] tx_word_reg;
  logic [VCS_WORD_MAX-1:0] tx_shift_reg;
  logic [VCS_CNT_W-1:0] tx_cnt_reg;
  logic tx_armed_reg;
  logic tx_data_reg;
  logic tx_oe_n_reg;
  logic tsx_n_reg;
  logic tx_ack_reg;
  logic tx_shift_ev;

  // (RL10) rises of the bit clock shift in variable mode
  assign tx_shift_ev = var_reg ? dcx.rise : mclk.rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= VCS_IDLE;
      tx_word_reg <= VCS_WORD_RST;
      tx_shift_reg <= VCS_WORD_RST;
      tx_cnt_reg <= VCS_CNT_ZERO;
      tx_armed_reg <= 1'b0;
      tx_data_reg <= 1'b0;
      tx_oe_n_reg <= 1'b1;
      tsx_n_reg <= 1'b1;
      tx_ack_reg <= 1'b0;
    end else begin
      tx_ack_reg <= 1'b0;
      case (tx_state_reg)
        VCS_IDLE: begin
          tx_oe_n_reg <= 1'b1;
          tsx_n_reg <= 1'b1;
          if (var_reg && tx_frame_sync.rise) begin
            // (RL9) bit 1 out on sync rise
            tx_word_reg <= tx_word_i;
            tx_shift_reg <= tx_word_i << 1;
            tx_data_reg <= tx_word_i[VCS_WORD_MAX-1];
            tx_oe_n_reg <= 1'b0;
            tx_cnt_reg <= VCS_CNT_ONE;
            tx_ack_reg <= 1'b1;
            tx_state_reg <= VCS_SHIFT;
          end else if (!var_reg && tx_frame_sync.level && mclk.fall) begin
            // (RL7) sync seen across a master clock fall
            tx_armed_reg <= 1'b1;
          end else if (!var_reg && tx_armed_reg && mclk.rise) begin
            // (RL4) (RL6) bit 1 and strobe on the rise
            tx_armed_reg <= 1'b0;
            tx_word_reg <= tx_word_i;
            tx_shift_reg <= tx_word_i << 1;
            tx_data_reg <= tx_word_i[VCS_WORD_MAX-1];
            tx_oe_n_reg <= 1'b0;
            tsx_n_reg <= 1'b0;
            tx_cnt_reg <= VCS_CNT_ONE;
            tx_ack_reg <= 1'b1;
            tx_state_reg <= VCS_SHIFT;
          end
        end
        VCS_SHIFT: begin
          if (var_reg && tx_frame_sync.fall) begin
            // (RL11) release on sync fall
            tx_oe_n_reg <= 1'b1;
            tx_state_reg <= VCS_IDLE;
          end else if (tx_cnt_reg == word_len) begin
            if (!var_reg && mclk.fall) begin
              // (RL5) (RL6) release after last bit fall
              tx_oe_n_reg <= 1'b1;
              tsx_n_reg <= 1'b1;
              tx_state_reg <= VCS_IDLE;
            end else if (var_reg && tx_shift_ev) begin
              // (RL15) repeat same word
              tx_shift_reg <= tx_word_reg << 1;
              tx_data_reg <= tx_word_reg[VCS_WORD_MAX-1];
              tx_cnt_reg <= VCS_CNT_ONE;
            end
          end else if (tx_shift_ev) begin
            // (RL1) MSB first
            tx_data_reg <= tx_shift_reg[VCS_WORD_MAX-1];
            tx_shift_reg <= tx_shift_reg << 1;
            tx_cnt_reg <= tx_cnt_reg + 1'b1;
          end
        end
        default: begin
          tx_oe_n_reg <= 1'b1;
          tsx_n_reg <= 1'b1;
          tx_state_reg <= VCS_IDLE;
        end
      endcase
    end
  end

  assign tx_data_o = tx_data_reg;
  assign tx_data_oe_n_o = tx_oe_n_reg;
  assign tx_slot_strobe_n_o = tsx_n_reg;
  assign tx_slot_strobe_oe_n_o = tsx_n_reg;
  assign tx_word_ack_o = tx_ack_reg;

  // Receive path, independent of transmit
  logic rx_active_reg;
  logic [VCS_WORD_MAX-1:0] rx_shift_reg;
  logic [VCS_CNT_W-1:0] rx_cnt_reg;
  logic [VCS_WORD_MAX-1:0] rx_word_reg;
  logic rx_valid_reg;
  logic rx_sample_ev;

  // (RL3) (RL12) falling edge of the governing clock
  assign rx_sample_ev = var_reg ? dcr.fall : mclk.fall;

  // (RL17) framed only by own sync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_active_reg <= 1'b0;
      rx_shift_reg <= VCS_WORD_RST;
      rx_cnt_reg <= VCS_CNT_ZERO;
      rx_word_reg <= VCS_WORD_RST;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_active_reg) begin
        // (RL8) sync across a clock fall; first bit taken with it
        if (rx_frame_sync.level && rx_sample_ev) begin
          rx_active_reg <= 1'b1;
          rx_shift_reg <= {{(VCS_WORD_MAX-1){1'b0}}, din.level};
          rx_cnt_reg <= VCS_CNT_ONE;
        end
      end else if (rx_sample_ev) begin
        // (RL1) MSB enters first
        rx_shift_reg <= {rx_shift_reg[VCS_WORD_MAX-2:0], din.level};
        rx_cnt_reg <= rx_cnt_reg + 1'b1;
        if (rx_cnt_reg + 1'b1 == word_len) begin
          rx_word_reg <= {rx_shift_reg[VCS_WORD_MAX-2:0], din.level};
          rx_valid_reg <= 1'b1;
          rx_active_reg <= 1'b0;
        end
      end
    end
  end

  assign rx_word_o = rx_word_reg;
  assign rx_word_valid_o = rx_valid_reg;
endmodule

// [hw/vcs_pkg.sv]
package vcs_pkg;
  localparam int unsigned VCS_COMP_BITS = 8;
  localparam int unsigned VCS_LIN_BITS = 16;
  localparam int unsigned VCS_WORD_MAX = 16;
  localparam int unsigned VCS_CNT_W = 5;
  localparam logic [VCS_CNT_W-1:0] VCS_CNT_COMP = 5'h08;
  localparam logic [VCS_CNT_W-1:0] VCS_CNT_LIN = 5'h10;
  localparam logic [VCS_CNT_W-1:0] VCS_CNT_ZERO = 5'h00;
  localparam logic [VCS_CNT_W-1:0] VCS_CNT_ONE = 5'h01;
  localparam logic [VCS_WORD_MAX-1:0] VCS_WORD_RST = 16'h0000;
  localparam logic [1:0] VCS_SYNC_RST = 2'h0;
  // Rx data clock held high this long (ns) means it is strapped: fixed-rate mode
  localparam int unsigned VCS_CLK_PERIOD_NS = 5;
  localparam int unsigned VCS_STRAP_NS = 2000;
  localparam int unsigned VCS_STRAP_CYC = VCS_STRAP_NS / VCS_CLK_PERIOD_NS;
  localparam int unsigned VCS_STRAP_W = 9;

  typedef enum logic [1:0] {
    VCS_IDLE = 2'b00,
    VCS_SHIFT = 2'b01,
    VCS_HOLD = 2'b11
  } vcs_tx_state_t;
endpackage

// [hw/vcs_edge_if.sv]
`timescale 1ns/1ps
interface vcs_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// [hw/vcs_pin_sync.sv]
`timescale 1ns/1ps
module vcs_pin_sync
  import vcs_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic pin_i, // Asynchronous pin
  vcs_edge_if.src edge_o // Synchronised level and edges
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Only sync_reg reads meta_reg
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign edge_o.level = sync_reg;
  assign edge_o.rise = sync_reg & ~prev_reg;
  assign edge_o.fall = ~sync_reg & prev_reg;
endmodule

// [verification/vcs_serial_port_properties.sv]
`timescale 1ns/1ps
module vcs_port_checker
  import vcs_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic linear_mode_i, // width
  input wire logic tx_frame_sync_i, // sync
  input wire logic tx_word_ack_o, // ack
  input wire logic tx_data_oe_n_o, // data oe
  input wire logic tx_slot_strobe_n_o, // strobe
  input wire logic tx_slot_strobe_oe_n_o, // strobe oe
  input wire logic [VCS_WORD_MAX-1:0] rx_word_o, // word
  input wire logic rx_word_valid_o, // valid
  input wire logic variable_rate_o // mode
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_STROBE_OE: assert property (
    tx_slot_strobe_oe_n_o == tx_slot_strobe_n_o) else $error("strobe enable differs");
  AST_FIXED_SLOT: assert property (
    !variable_rate_o |-> tx_data_oe_n_o == tx_slot_strobe_n_o) else $error("slot mismatch");
  AST_ACK_START: assert property (
    tx_word_ack_o |-> ##[0:1] !tx_data_oe_n_o) else $error("ack without drive");
  AST_VALID_PULSE: assert property (
    rx_word_valid_o |=> !rx_word_valid_o) else $error("valid too long");
  AST_WORD_HOLD: assert property (
    $changed(rx_word_o) |-> rx_word_valid_o) else $error("word moved alone");
  AST_COMP_WIDTH: assert property (
    rx_word_valid_o && !linear_mode_i |-> rx_word_o[15:8] == 8'h00) else $error("wide word");
  AST_VAR_RELEASE: assert property (
    (variable_rate_o && !tx_frame_sync_i) [*8] |-> tx_data_oe_n_o) else $error("not released");
  AST_VAR_START: assert property (
    variable_rate_o && $rose(tx_frame_sync_i) |-> ##[1:6] !tx_data_oe_n_o)
    else $error("late first bit");
endmodule
bind vcs_serial_port vcs_port_checker vcs_port_checker_i (.clk_i, .rst_i, .linear_mode_i,
  .tx_frame_sync_i, .tx_word_ack_o, .tx_data_oe_n_o, .tx_slot_strobe_n_o,
  .tx_slot_strobe_oe_n_o, .rx_word_o, .rx_word_valid_o, .variable_rate_o);

// [verification/vcs_host_model.sv]
`timescale 1ns/1ps
module vcs_host_model (
  output logic mclk_o, // master clock
  output logic tx_sync_o, // tx frame sync
  output logic rx_sync_o, // rx frame sync
  output logic tx_bclk_o, // tx data clock
  output logic rx_bclk_o, // rx data clock
  output logic rx_data_o, // serial to device
  input wire logic tx_data_i, // serial from device
  input wire logic tx_oe_n_i, // data enable
  input wire logic tx_stb_n_i // slot strobe
);
  logic vm = 1'b0;
  logic gtx = 1'b0;
  logic grx = 1'b0;
  assign tx_bclk_o = mclk_o & gtx;
  assign rx_bclk_o = vm ? mclk_o & grx : 1'b1;
  initial begin
    {mclk_o, tx_sync_o, rx_sync_o, rx_data_o} = 4'h0;
    #1.3;
    forever #62.5 mclk_o = ~mclk_o;
  end
  // t counts transmit bits: above n repeats the word, below n cuts it short
  task automatic frame(input logic [15:0] w, input int n, input int t, output logic [15:0] got);
    int j;
    int last;
    got = 16'h0000;
    last = (t > n) ? t : n;
    for (int k = 0; k <= last; k++) begin
      @(posedge mclk_o);
      j = k + 1 - int'(vm);
      rx_data_o = (j >= 1 && j <= n) ? w[16-j] : ~rx_data_o;
      tx_sync_o = (k == 0) || (vm && k < t);
      rx_sync_o = (k == 0) || (vm && k < n);
      @(negedge mclk_o);
      gtx = vm && k < t - 1;
      grx = vm && k < n;
      // Undriven bits turn to x so a compare fails
      if (k >= 1 - int'(vm) && k <= t - int'(vm))
        got = {got[14:0], tx_oe_n_i | (tx_stb_n_i & !vm) ? 1'bx : tx_data_i};
    end
  endtask
endmodule

// [verification/vcs_serial_port_tb_top.sv]
`timescale 1ns/1ps
module vcs_serial_port_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, lin = 1'b0;
  logic [15:0] word = 16'h0000, rx_word;
  logic mclk, txs, rxs, txb, rxb, rxd, txd, oe_n, stb_n, rx_valid, var_rate;
  int num_errors = 0, num_checks = 0, seed = 41565, n_valid = 0, n = 8;
  initial forever #2.5 clk_i = ~clk_i;
  vcs_serial_port vcs_serial_port_i (.clk_i, .rst_i, .linear_mode_i(lin), .master_clock_i(mclk),
    .tx_frame_sync_i(txs), .rx_frame_sync_i(rxs), .tx_bit_clock_i(txb), .rx_bit_clock_i(rxb),
    .rx_data_i(rxd), .tx_word_i(word), .tx_word_ack_o(), .tx_data_o(txd),
    .tx_data_oe_n_o(oe_n), .tx_slot_strobe_n_o(stb_n), .tx_slot_strobe_oe_n_o(),
    .rx_word_o(rx_word), .rx_word_valid_o(rx_valid), .variable_rate_o(var_rate));
  vcs_host_model vcs_host_model_i (.mclk_o(mclk), .tx_sync_o(txs), .rx_sync_o(rxs),
    .tx_bclk_o(txb), .rx_bclk_o(rxb), .rx_data_o(rxd), .tx_data_i(txd), .tx_oe_n_i(oe_n),
    .tx_stb_n_i(stb_n));
  always @(posedge clk_i) if (rx_valid === 1'b1) n_valid++;
  function automatic logic [15:0] expect_word(input logic [15:0] w, input int len);
    return w >> (16 - len);
  endfunction
  // Last 16 transmit bits; the word starts over after len bits
  function automatic logic [15:0] expect_tx(input logic [15:0] w, input int len, input int t);
    logic [15:0] e;
    e = 16'h0000;
    for (int b = 0; b < t; b++) e = {e[14:0], w[15 - (b % len)]};
    return e;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic set_mode(input logic v);
    int i;
    vcs_host_model_i.vm = v;
    for (i = 0; i < 600 && var_rate !== v; i++) @(negedge clk_i);
    chk("mode", 16'(v), 16'(var_rate));
    if (var_rate !== v) wrap_up;
  endtask
  // Frames follow back to back: next sync rises on the next master rise
  task automatic run(input logic [15:0] w, input int t);
    logic [15:0] got;
    int nv;
    nv = n_valid;
    word = w;
    vcs_host_model_i.frame(w, n, t, got);
    chk("tx word", expect_tx(w, n, t), got);
    repeat (8) @(negedge clk_i);
    chk("rx word", expect_word(w, n), rx_word);
    chk("rx valid count", 16'h0001, 16'(n_valid - nv));
    chk("released", 16'h0003, {14'h0000, oe_n, stb_n});
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    for (int m = 0; m < 4; m++) begin
      lin = m[0];
      n = lin ? 16 : 8;
      set_mode(m[1]);
      run(16'hFFFF, n);
      run(16'h8001, n);
      for (int r = 0; r < 4; r++) run(16'($random(seed)), n);
      // variable rate: repeat, then cut short
      if (m[1]) begin
        run(16'($random(seed)), 2 * n);
        run(16'($random(seed)), n / 2 + 1);
      end
      $display("done variable %0d linear %0d", m[1], lin);
    end
    // Second reset mid-run: back to idle and fixed rate
    rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("mode after reset", 16'h0000, 16'(var_rate));
    chk("idle after reset", 16'h0003, {14'h0000, oe_n, stb_n});
    chk("rx word after reset", 16'h0000, rx_word);
    $display("done reset");
    wrap_up;
  end
endmodule
